// >>> shared/rpq_consts.vh
// Purpose: constants for the payload queue status block
// Assumes: 8-bit registers on the command port, printed offsets
// Notes: offsets are register indices of the transceiver map
`ifndef RPQ_CONSTS_VH
`define RPQ_CONSTS_VH
`define RPQ_OFS_PIPE4_RX_WIDTH 5'h15
`define RPQ_OFS_PIPE5_RX_WIDTH 5'h16
`define RPQ_OFS_QUEUE_STATE 5'h17
`define RPQ_WIDTH_RESET 8'h00
`define RPQ_BIT_REUSE 6
`define RPQ_BIT_TX_FULL 5
`define RPQ_BIT_TX_EMPTY 4
`define RPQ_BIT_RX_FULL 1
`define RPQ_BIT_RX_EMPTY 0
`define RPQ_WIDTH_MSB 5
`define RPQ_MAX_LEN 6'h20
`define RPQ_DEPTH 3
`define RPQ_REPEAT_HOLD_NS 10000
`define RPQ_CLK_PERIOD_NS 4
`define RPQ_REPEAT_HOLD_CYC ((`RPQ_REPEAT_HOLD_NS + `RPQ_CLK_PERIOD_NS - 1) / `RPQ_CLK_PERIOD_NS)
`endif

// >>> src/rpq_payload_status.v
// Purpose: payload queues, pipe 4/5 widths and queue status register
// Assumes: command decode upstream gives single-cycle strobes on the core clock
// Notes: payloads move as whole 32-byte words with a separate length
//
// Overview of operation
// [R01] pipe 4 width is six bits, zero means unused, 1..32 is the byte count.
// [R02] pipe 5 width is six bits, resets to zero, else 1..32 bytes.
// [R03] status bit 6 sets on the repeat command and clears on tx load or tx flush.
// [R04] the host holds chip enable high at least 10 us to resend during repeat.
// [R05] status bit 5 is tx full and bit 4 tx empty, which resets to one.
// [R06] status bit 1 is rx full and bit 0 rx empty, which resets to one.
// [R07] ack payloads are write-only, tagged by pipe, sent only on that pipe in rx mode.
// [R08] at most three ack payloads pend, and same-pipe ones go out in fifo order.
// [R09] the tx store is a three-entry queue, loaded by command, drained only in tx mode.
// [R10] all pipes share one three-level rx queue drained by a read command.
// [R11] full means all three entries taken and empty means none, for both queues.
// [R12] reserved bits of the status and width registers read as zero.
`timescale 1ns/100ps
`include "rpq_consts.vh"
module rpq_payload_status #(
  parameter DEPTH = `RPQ_DEPTH,
  parameter HOLD_CYC = `RPQ_REPEAT_HOLD_CYC
) (
  input wire i_core_clk, // core clock, 250 MHz
  input wire i_rst_n, // async reset, active low
  input wire i_reg_wr, // register write strobe
  input wire i_reg_rd, // register read strobe
  input wire [4:0] i_reg_addr, // register index
  input wire [7:0] i_reg_wdata, // register write data
  output reg [7:0] o_reg_rdata, // register read data
  input wire i_tx_load, // load tx payload command
  input wire i_tx_flush, // flush tx command
  input wire i_repeat_last_cmd, // repeat last payload command
  input wire [255:0] i_pld_data, // payload bytes, byte 0 in [7:0]
  input wire [5:0] i_pld_len, // payload length 1..32
  input wire i_ack_load, // load ack payload command
  input wire [2:0] i_pipe_index, // pipe for the ack payload
  input wire i_rx_read, // read rx payload command
  input wire i_rx_flush, // flush rx command
  output reg [255:0] o_rx_data, // head rx payload
  output reg [5:0] o_rx_len, // head rx length
  output reg [2:0] o_rx_pipe, // head rx pipe
  input wire i_tx_mode, // radio in transmit mode
  input wire i_chip_enable, // chip enable pin, async
  input wire i_tx_sent, // radio finished a tx payload
  output reg o_tx_valid, // tx payload available
  output reg [255:0] o_tx_data, // tx payload to the radio
  output reg [5:0] o_tx_len, // tx payload length
  output wire o_resend, // retransmit last payload pulse
  input wire i_rx_store, // radio delivers a received payload
  input wire [255:0] i_rx_payload_queue, // received payload bytes
  input wire [5:0] i_rx_payload_queue_len, // received length
  input wire [2:0] i_rx_payload_queue_pipe, // received pipe
  input wire i_ack_req, // radio asks ack payload for a pipe
  input wire [2:0] i_ack_req_pipe, // pipe of the ack request
  output reg o_ack_hit, // ack payload found for the pipe
  output reg [255:0] o_ack_data, // ack payload bytes
  output reg [5:0] o_ack_len, // ack payload length
  output wire o_rx_width_ok // received length matches pipe width
);
  reg [5:0] p4_width_reg;
  reg [5:0] p5_width_reg;
  reg reuse_reg;
  reg ce_meta_reg;
  reg ce_sync_reg;
  reg [13:0] hold_reg;
  reg resend_done_reg;
  reg [264:0] ack_mem [0:DEPTH-1];
  reg [DEPTH-1:0] ack_vld_reg;
  reg [1:0] ack_pick;
  reg ack_found;
  reg [1:0] free_slot;
  reg free_found;
  integer i;
  integer j; // own index, so the lookup process never sees it move
  wire [261:0] tx_head;
  wire [264:0] rx_head;
  wire tx_full;
  wire tx_empty;
  wire rx_full;
  wire rx_empty;
  wire tx_pop;
  wire [7:0] status;

  // [R09] tx queue, pop only while transmitting
  assign tx_pop = i_tx_sent && i_tx_mode && !reuse_reg;
  rpq_queue #(.DW(262), .DEPTH(DEPTH)) u_txq (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_flush(i_tx_flush),
    .i_push(i_tx_load),
    .i_data({i_pld_len, i_pld_data}),
    .i_pop(tx_pop),
    .o_head(tx_head),
    .o_count(),
    .o_full(tx_full),
    .o_empty(tx_empty)
  );

  // [R10] one rx queue shared by all pipes
  rpq_queue #(.DW(265), .DEPTH(DEPTH)) u_rxq (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_flush(i_rx_flush),
    .i_push(i_rx_store),
    .i_data({i_rx_payload_queue_pipe, i_rx_payload_queue_len, i_rx_payload_queue}),
    .i_pop(i_rx_read),
    .o_head(rx_head),
    .o_count(),
    .o_full(rx_full),
    .o_empty(rx_empty)
  );

  // [R05] [R06] [R12] status word, reserved bits zero
  assign status = {1'b0, reuse_reg, tx_full, tx_empty, 2'b00, rx_full, rx_empty};

  // [R01] [R02] width registers, six bits kept
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      p4_width_reg <= 6'h00;
      p5_width_reg <= 6'h00;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == `RPQ_OFS_PIPE4_RX_WIDTH)
        p4_width_reg <= i_reg_wdata[`RPQ_WIDTH_MSB:0];
      if (i_reg_addr == `RPQ_OFS_PIPE5_RX_WIDTH)
        p5_width_reg <= i_reg_wdata[`RPQ_WIDTH_MSB:0];
    end
  end

  // [R12] register read, unmapped reads zero
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
    begin
      case (i_reg_addr)
        `RPQ_OFS_PIPE4_RX_WIDTH: o_reg_rdata <= {2'b00, p4_width_reg};
        `RPQ_OFS_PIPE5_RX_WIDTH: o_reg_rdata <= {2'b00, p5_width_reg};
        `RPQ_OFS_QUEUE_STATE: o_reg_rdata <= status;
        default: o_reg_rdata <= 8'h00;
      endcase
    end
  end

  // [R01] [R02] width check for fixed-length pipes; zero means pipe unused
  assign o_rx_width_ok = (i_rx_payload_queue_pipe == 3'h4) ? (p4_width_reg != 6'h00 &&
                         p4_width_reg <= `RPQ_MAX_LEN && i_rx_payload_queue_len == p4_width_reg) :
                         (i_rx_payload_queue_pipe == 3'h5) ? (p5_width_reg != 6'h00 &&
                         p5_width_reg <= `RPQ_MAX_LEN && i_rx_payload_queue_len == p5_width_reg) :
                         1'b1;

  // [R03] repeat flag, load or flush clears, set wins in a tie
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      reuse_reg <= 1'b0;
    else if (i_repeat_last_cmd)
      reuse_reg <= 1'b1;
    else if (i_tx_load || i_tx_flush)
      reuse_reg <= 1'b0;
  end

  // chip enable pin synchroniser
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ce_meta_reg <= 1'b0;
      ce_sync_reg <= 1'b0;
    end
    else
    begin
      ce_meta_reg <= i_chip_enable;
      ce_sync_reg <= ce_meta_reg;
    end
  end

  // [R04] resend only after enable held the full time, once per high phase
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      hold_reg <= 14'h0000;
      resend_done_reg <= 1'b0;
    end
    else if (!ce_sync_reg || !reuse_reg)
    begin
      hold_reg <= 14'h0000;
      resend_done_reg <= 1'b0;
    end
    else if (hold_reg != HOLD_CYC[13:0])
      hold_reg <= hold_reg + 14'h0001;
    else
      resend_done_reg <= 1'b1;
  end
  assign o_resend = reuse_reg && i_tx_mode && !tx_empty &&
                    (hold_reg == HOLD_CYC[13:0]) && !resend_done_reg;

  // [R09] tx valid raised only in tx mode, tx head data and length driven in every mode
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_tx_valid <= 1'b0;
      o_tx_data <= 256'h0;
      o_tx_len <= 6'h00;
      o_rx_data <= 256'h0;
      o_rx_len <= 6'h00;
      o_rx_pipe <= 3'h0;
    end
    else
    begin
      o_tx_valid <= i_tx_mode && !tx_empty;
      o_tx_data <= tx_head[255:0];
      o_tx_len <= tx_head[261:256];
      o_rx_data <= rx_head[255:0];
      o_rx_len <= rx_head[261:256];
      o_rx_pipe <= rx_head[264:262];
    end
  end

  // [R08] oldest matching slot, slots kept in arrival order
  always @*
  begin
    ack_pick = 2'h0;
    ack_found = 1'b0;
    free_slot = 2'h0;
    free_found = 1'b0;
    for (i = DEPTH - 1; i >= 0; i = i - 1)
    begin
      if (ack_vld_reg[i] && ack_mem[i][264:262] == i_ack_req_pipe)
      begin
        ack_pick = i[1:0];
        ack_found = 1'b1;
      end
      if (!ack_vld_reg[i])
      begin
        free_slot = i[1:0];
        free_found = 1'b1;
      end
    end
  end

  // [R07] [R08] ack store: compacting queue, at most three pending
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      ack_vld_reg <= {DEPTH{1'b0}};
      o_ack_hit <= 1'b0;
      o_ack_data <= 256'h0;
      o_ack_len <= 6'h00;
    end
    else
    begin
      o_ack_hit <= i_ack_req && !i_tx_mode && ack_found;
      o_ack_data <= ack_mem[ack_pick][255:0];
      o_ack_len <= ack_mem[ack_pick][261:256];
      if (i_tx_flush)
        ack_vld_reg <= {DEPTH{1'b0}};
      else if (i_ack_req && !i_tx_mode && ack_found)
      begin
        // shift younger entries down to keep age order
        for (j = 0; j < DEPTH - 1; j = j + 1)
          if (j >= ack_pick)
          begin
            ack_mem[j] <= ack_mem[j + 1];
            ack_vld_reg[j] <= ack_vld_reg[j + 1];
          end
        ack_vld_reg[DEPTH-1] <= 1'b0;
      end
      else if (i_ack_load && free_found)
      begin
        ack_mem[free_slot] <= {i_pipe_index, i_pld_len, i_pld_data};
        ack_vld_reg[free_slot] <= 1'b1;
      end
    end
  end
endmodule // rpq_payload_status

// >>> src/rpq_queue.v
// Purpose: three-entry payload queue, one payload per entry
// Assumes: pushes and pops are single-cycle pulses on the core clock
// Notes: a push when full and a pop when empty are ignored
`timescale 1ns/100ps
module rpq_queue #(
  parameter DW = 264,
  parameter DEPTH = 3
) (
  input wire i_core_clk, // core clock
  input wire i_rst_n, // async reset, active low
  input wire i_flush, // drop all entries
  input wire i_push, // write one entry
  input wire [DW-1:0] i_data, // entry to write
  input wire i_pop, // drop the head entry
  output wire [DW-1:0] o_head, // head entry
  output wire [1:0] o_count, // entries held
  output wire o_full, // all entries taken
  output wire o_empty // no entry held
);
  reg [DW-1:0] mem [0:DEPTH-1];
  reg [1:0] wr_reg;
  reg [1:0] rd_reg;
  reg [1:0] cnt_reg;
  wire do_push;
  wire do_pop;
  // refuse overrun and underrun so the count stays honest
  assign do_push = i_push && (cnt_reg != DEPTH[1:0]);
  assign do_pop = i_pop && (cnt_reg != 2'h0);
  assign o_head = mem[rd_reg];
  assign o_count = cnt_reg;
  // [R11] full and empty flags
  assign o_full = (cnt_reg == DEPTH[1:0]);
  assign o_empty = (cnt_reg == 2'h0);
  // pointers and level
  always @(posedge i_core_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      wr_reg <= 2'h0;
      rd_reg <= 2'h0;
      cnt_reg <= 2'h0;
    end
    else if (i_flush)
    begin
      wr_reg <= 2'h0;
      rd_reg <= 2'h0;
      cnt_reg <= 2'h0;
    end
    else
    begin
      if (do_push)
        wr_reg <= (wr_reg == DEPTH[1:0] - 2'h1) ? 2'h0 : wr_reg + 2'h1;
      if (do_pop)
        rd_reg <= (rd_reg == DEPTH[1:0] - 2'h1) ? 2'h0 : rd_reg + 2'h1;
      if (do_push && !do_pop)
        cnt_reg <= cnt_reg + 2'h1;
      else if (do_pop && !do_push)
        cnt_reg <= cnt_reg - 2'h1;
    end
  end
  // storage, no reset needed for payload bytes
  always @(posedge i_core_clk)
  begin
    if (do_push)
      mem[wr_reg] <= i_data;
  end
endmodule // rpq_queue

// >>> testbench/radio_payload_fifo_status_tb_top.sv
// Purpose: directed bench for the payload status block
// Assumes: strobes driven 1 ns after the rising edge
// Notes: payload, length and pipe inputs share one driver each
`timescale 1ns/100ps
`include "rpq_consts.vh"
module radio_payload_fifo_status_tb_top;
  localparam [4:0] AW4 = `RPQ_OFS_PIPE4_RX_WIDTH;
  localparam [4:0] AW5 = `RPQ_OFS_PIPE5_RX_WIDTH;
  localparam [4:0] AST = `RPQ_OFS_QUEUE_STATE;
  localparam [10:0] LD = 1, FL = 2, RP = 4, AL = 8, RR = 16, RF = 32;
  localparam [10:0] SN = 64, ST = 128, AQ = 256, WR = 512, RD = 1024;
  reg clk, rst_n, tx_mode, ce_go;
  reg [10:0] cmd;
  reg [4:0] addr;
  reg [7:0] wd;
  reg [255:0] pld;
  reg [5:0] len;
  reg [2:0] pp;
  integer bad_count, n_tests, i, seen;
  wire [7:0] rdata;
  wire [255:0] rxd, txd, ackd;
  wire [5:0] rxl, txl, ackl;
  wire [2:0] rxp;
  wire txv, rsd, hit, wok, ce;
  // clock, 4 ns period
  always #2 clk = ~clk;
  rpq_payload_status #(.HOLD_CYC(8)) i_dut (.i_core_clk(clk), .i_rst_n(rst_n),
    .i_reg_wr(cmd[9]), .i_reg_rd(cmd[10]), .i_reg_addr(addr), .i_reg_wdata(wd),
    .o_reg_rdata(rdata), .i_tx_load(cmd[0]), .i_tx_flush(cmd[1]),
    .i_repeat_last_cmd(cmd[2]), .i_pld_data(pld), .i_pld_len(len), .i_ack_load(cmd[3]),
    .i_pipe_index(pp), .i_rx_read(cmd[4]), .i_rx_flush(cmd[5]), .o_rx_data(rxd),
    .o_rx_len(rxl), .o_rx_pipe(rxp), .i_tx_mode(tx_mode), .i_chip_enable(ce),
    .i_tx_sent(cmd[6]), .o_tx_valid(txv), .o_tx_data(txd), .o_tx_len(txl),
    .o_resend(rsd), .i_rx_store(cmd[7]), .i_rx_payload_queue(pld), .i_rx_payload_queue_len(len),
    .i_rx_payload_queue_pipe(pp), .i_ack_req(cmd[8]), .i_ack_req_pipe(pp), .o_ack_hit(hit),
    .o_ack_data(ackd), .o_ack_len(ackl), .o_rx_width_ok(wok));
  rpq_host_model #(.HOLD(20)) i_host (.i_core_clk(clk), .i_go(ce_go), .o_ce(ce));
  // one strobe cycle, then a quiet cycle so no signal is set twice at once
  task go(input [10:0] m);
    @(posedge clk);
    #1 cmd = m;
    @(posedge clk);
    #1 cmd = 11'h000;
  endtask
  task chk(input logic [255:0] g, input logic [255:0] e);
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("[FAIL] %0t got %h want %h", $time, g, e);
    end
  endtask
  task rdc(input [4:0] a, input [7:0] e);
    addr = a;
    go(RD);
    chk(rdata, e);
  endtask
  task wrr(input [4:0] a, input [7:0] d);
    addr = a;
    wd = d;
    go(WR);
  endtask
  task ld(input [10:0] m, input [255:0] d, input [5:0] l, input [2:0] p);
    pld = d;
    len = l;
    pp = p;
    go(m);
  endtask
  task t_reset;
    rdc(AST, 8'h11);
    rdc(AW4, 8'h00);
    rdc(AW5, 8'h00);
    rdc(5'h1f, 8'h00);
  endtask
  task t_width;
    wrr(AW4, 8'hff);
    rdc(AW4, 8'h3f);
    wrr(AW5, 8'h20);
    rdc(AW5, 8'h20);
    len = 6'h20;
    pp = 3'd5;
    #1 chk(wok, 1'b1);
    len = 6'h1f;
    #1 chk(wok, 1'b0);
    pp = 3'd4;
    len = 6'h3f;
    #1 chk(wok, 1'b0); // width above 32 never matches
  endtask
  task t_tx;
    tx_mode = 1'b1;
    for (i = 1; i < 5; i = i + 1)
      ld(LD, i, 6'h20, 3'd0);
    rdc(AST, 8'h21);
    chk(txv, 1'b1);
    chk(txd, 256'h1);
    chk(txl, 6'h20);
    go(SN);
    rdc(AST, 8'h01);
    chk(txd, 256'h2);
    go(SN);
    go(SN);
    rdc(AST, 8'h11);
  endtask
  task t_rep;
    ld(LD, 256'h5, 6'h04, 3'd0);
    go(RP);
    rdc(AST, 8'h41);
    go(SN);
    ce_go = 1'b1;
    @(posedge clk);
    #1 ce_go = 1'b0;
    seen = 0;
    repeat (40)
    begin
      @(posedge clk);
      #1 if (rsd === 1'b1) seen = seen + 1;
    end
    chk(seen, 1);
    rdc(AST, 8'h41);
    ld(LD, 256'h6, 6'h04, 3'd0);
    rdc(AST, 8'h01);
    go(RP);
    go(FL);
    rdc(AST, 8'h11);
  endtask
  task t_rx;
    tx_mode = 1'b0;
    ld(LD, 256'h7, 6'h04, 3'd0);
    go(SN);
    rdc(AST, 8'h01); // no drain outside tx mode
    chk(txv, 1'b0);
    go(FL);
    for (i = 1; i < 4; i = i + 1)
      ld(ST, 256'h10 + i, 6'h20, i);
    rdc(AST, 8'h12);
    chk(rxd, 256'h11);
    chk(rxl, 6'h20);
    go(RR);
    rdc(AST, 8'h10);
    chk(rxp, 3'd2);
    go(RF);
    rdc(AST, 8'h11);
  endtask
  task t_ack;
    for (i = 0; i < 4; i = i + 1)
      ld(AL, 256'h21 + i, 6'h08, 2 + i / 2);
    pp = 3'd2;
    go(AQ);
    chk(hit, 1'b1);
    chk(ackd, 256'h21);
    go(AQ);
    chk(ackd, 256'h22);
    pp = 3'd3;
    go(AQ);
    chk(ackl, 6'h08);
    go(AQ);
    chk(hit, 1'b0);
    ld(AL, 256'h25, 6'h08, 3'd3);
    tx_mode = 1'b1;
    go(AQ);
    chk(hit, 1'b0);
  endtask
  task conclude;
    $display("counts: bad %0d tests %0d", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // main sequence, reset held 12 cycles
  initial
  begin
    {clk, rst_n, tx_mode, ce_go, cmd, addr, wd, pld, len, pp} = 0;
    bad_count = 0;
    n_tests = 0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    t_reset;
    t_width;
    t_tx;
    t_rep;
    t_rx;
    t_ack;
    conclude;
  end
  // watchdog, about sixty times the expected run
  initial
  begin
    #40000;
    bad_count = bad_count + 1;
    conclude;
  end
endmodule // radio_payload_fifo_status_tb_top

// >>> testbench/rpq_host_model.sv
// Purpose: host side chip-enable driver for payload repetition
// Assumes: host moves its pin just after the core clock edge
// Notes: hold length is a parameter so short runs stay short
`timescale 1ns/100ps
module rpq_host_model #(
  parameter HOLD = 20
) (
  input wire i_core_clk, // clock
  input wire i_go, // start one chip-enable phase
  output reg o_ce // chip enable pin
);
  // minimum high time
  // one high phase per request, held past the device threshold
  initial
  begin
    o_ce = 1'b0;
    forever
    begin
      @(posedge i_core_clk);
      if (i_go)
      begin
        #1 o_ce = 1'b1;
        repeat (HOLD) @(posedge i_core_clk);
        #1 o_ce = 1'b0;
      end
    end
  end
endmodule // rpq_host_model

// >>> testbench/rpq_payload_status_properties.sv
// Purpose: port-level checks for the payload status block
// Assumes: one core clock, async active-low reset
// Notes: queue flags are seen only through status reads
`timescale 1ns/100ps
module rpq_payload_status_props #(
  parameter HOLD_CYC = 8
) (
  input wire i_core_clk, // clock
  input wire i_rst_n, // reset, active low
  input wire i_reg_rd, // read strobe
  input wire [4:0] i_reg_addr, // register index
  input wire [7:0] o_reg_rdata, // read data
  input wire i_tx_load, // tx load
  input wire i_tx_flush, // tx flush
  input wire i_repeat_last_cmd, // repeat command
  input wire i_tx_mode, // tx mode
  input wire o_tx_valid, // tx head valid
  input wire i_ack_req, // ack request
  input wire o_ack_hit, // ack hit
  input wire i_chip_enable, // chip enable pin
  input wire o_resend // resend pulse
);
  reg [11:0] ce_cnt_reg;
  // status read in flight
  wire st_rd = i_reg_rd && (i_reg_addr == 5'h17);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  // raw chip-enable high time, saturating so long holds never wrap
  always @(posedge i_core_clk or negedge i_rst_n)
    if (!i_rst_n)
      ce_cnt_reg <= 12'h000;
    else if (!i_chip_enable)
      ce_cnt_reg <= 12'h000;
    else if (ce_cnt_reg != 12'hfff)
      ce_cnt_reg <= ce_cnt_reg + 12'h001;
  a_resv_zero:
    assert property (st_rd |=> o_reg_rdata[7] == 1'b0 && o_reg_rdata[3:2] == 2'b00)
    else $error("status reserved bits not zero");
  a_width_top:
    assert property (i_reg_rd && (i_reg_addr == 5'h15 || i_reg_addr == 5'h16)
      |=> o_reg_rdata[7:6] == 2'b00) else $error("width top bits not zero");
  a_repeat_set:
    assert property (st_rd && $past(i_repeat_last_cmd, 2) && !$past(i_tx_load)
      && !$past(i_tx_flush) |=> o_reg_rdata[6]) else $error("repeat flag not set");
  a_flush_clr:
    assert property (st_rd && $past(i_tx_flush, 2) && !$past(i_repeat_last_cmd, 2)
      && !$past(i_repeat_last_cmd) |=> !o_reg_rdata[6]) else $error("flush kept repeat");
  a_flag_excl:
    assert property (st_rd |=> !(o_reg_rdata[5] && o_reg_rdata[4])
      && !(o_reg_rdata[1] && o_reg_rdata[0])) else $error("full and empty together");
  a_tx_only:
    assert property (!i_tx_mode ##1 !i_tx_mode |-> !o_tx_valid)
    else $error("tx valid outside tx mode");
  a_ack_rxmode:
    assert property (i_ack_req && i_tx_mode |=> !o_ack_hit) else $error("ack hit in tx mode");
  a_hit_cause:
    assert property (o_ack_hit |-> $past(i_ack_req)) else $error("ack hit without request");
  a_resend_hold:
    assert property (o_resend |-> ce_cnt_reg >= HOLD_CYC) else $error("resend too early");
  c_resend: cover property (o_resend);
  c_ack_hit: cover property (o_ack_hit);
  c_repeat: cover property (i_repeat_last_cmd ##[1:4] st_rd);
endmodule // rpq_payload_status_props

bind rpq_payload_status rpq_payload_status_props #(.HOLD_CYC(HOLD_CYC)) i_props (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_reg_rd(i_reg_rd),
  .i_reg_addr(i_reg_addr), .o_reg_rdata(o_reg_rdata), .i_tx_load(i_tx_load),
  .i_tx_flush(i_tx_flush), .i_repeat_last_cmd(i_repeat_last_cmd), .i_tx_mode(i_tx_mode),
  .o_tx_valid(o_tx_valid), .i_ack_req(i_ack_req), .o_ack_hit(o_ack_hit),
  .i_chip_enable(i_chip_enable), .o_resend(o_resend));
